// File: hdl/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define WDT_CLK_HZ        125000000
`define WDT_OSC_HZ        400000
`define WDT_OSC_DIV       (`WDT_CLK_HZ / `WDT_OSC_HZ)
`define WDT_RST_LEN       5'h10

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define WDT_OFF_CTRL      5'h00
`define WDT_OFF_RELOAD    5'h04
`define WDT_OFF_FEED      5'h08
`define WDT_OFF_COUNT     5'h0c
`define WDT_OFF_STATUS    5'h10
`define WDT_OFF_MASK      5'h14
`define WDT_OFF_AUX       5'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define WDT_CTRL_WDE      0
`define WDT_CTRL_RUN      1
`define WDT_CTRL_OSC      2
`define WDT_CTRL_TAP_LO   4
`define WDT_CTRL_TAP_HI   6
`define WDT_AUX_SWRST     0
`define WDT_ST_TIMER      0
`define WDT_ST_WDOG       1
`define WDT_ST_SWRST      2
`define WDT_TAP_BASE      4

// ****************************************************************
// Reset values and feed bytes
// ****************************************************************
`define WDT_RST_RELOAD    8'hff
`define WDT_RST_TAP       3'h7
`define WDT_FEED_FIRST    8'ha5
`define WDT_FEED_SECOND   8'h5a

`endif

// File: hdl/wdt_pkg.sv
package wdt_pkg;

    typedef enum logic [1:0] {
        WDT_FEED_IDLE  = 2'b00,
        WDT_FEED_ARMED = 2'b01
    } wdt_feed_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } wdt_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } wdt_avs_rsp_t;

    typedef struct packed {
        logic        watchdog_mode_enable;
        logic        run;
        logic        osc;
        logic [2:0]  tap;
        logic [7:0]  reload;
        logic [7:0]  count;
        logic [11:0] presc;
        wdt_feed_t   feed;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [4:0]  rst_cnt;
        logic        sys_rst;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
    } wdt_state_t;

    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } wdt_div_state_t;

endpackage

// File: hdl/wdt_osc_div.sv
`include "wdt_defs.svh"

module wdt_osc_div #(
    parameter int DIV = `WDT_OSC_DIV
) (
    input  wire logic clk_i,
    input  wire logic software_reset_bit_i,
    output logic      tick_o
);
    import wdt_pkg::*;

    localparam logic [11:0] LAST = 12'(DIV - 1);

    wdt_div_state_t q;
    wdt_div_state_t next_q;

    // ****************************************************************
    // Slow oscillator as a one-cycle enable
    // ****************************************************************
    always_comb
    begin
        next_q = q;
        next_q.tick = 1'b0;
        if (q.cnt == LAST)
        begin
            next_q.cnt = 12'h000;
            next_q.tick = 1'b1;
        end
        else
        begin
            next_q.cnt = q.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (software_reset_bit_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign tick_o = q.tick;
endmodule

// File: hdl/wdt_top.sv
`include "wdt_defs.svh"

module wdt_top #(
    parameter int OSC_DIV = `WDT_OSC_DIV,
    parameter int RST_LEN = `WDT_RST_LEN
) (
    input  wire logic                  clk_i,
    input  wire logic                  software_reset_bit_i,
    input  wire wdt_pkg::wdt_avs_req_t avs_req_i,
    input  wire logic                  pd_i,
    output wdt_pkg::wdt_avs_rsp_t      avs_rsp_o,
    output logic                       sys_rst_o,
    output logic                       irq_o
);
    import wdt_pkg::*;

    localparam logic [4:0] RST_CNT = 5'(RST_LEN);

    wdt_state_t q;
    wdt_state_t next_q;
    logic       osc_tick;

    // ****************************************************************
    // Slow oscillator enable
    // ****************************************************************
    // Same clock as the core, so every tick lands in one cycle
    wdt_osc_div #(
        .DIV    (OSC_DIV)
    ) u_osc (
        .clk_i  (clk_i),
        .software_reset_bit_i (software_reset_bit_i),
        .tick_o (osc_tick)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Carry out of the chosen prescaler stage
    function automatic logic tap_hit(
        input logic [11:0] presc,
        input logic [2:0]  tap
    );
        logic [3:0]  top;
        logic [11:0] low_mask;
        top = 4'(`WDT_TAP_BASE) + {1'b0, tap};
        low_mask = 12'hfff >> (4'hb - top);
        tap_hit = &(presc | ~low_mask);
    endfunction

    // Power-on defaults; no other reset reaches these fields
    function automatic wdt_state_t rst_state();
        rst_state         = '0;
        rst_state.reload  = `WDT_RST_RELOAD;
        rst_state.count   = `WDT_RST_RELOAD;
        rst_state.tap     = `WDT_RST_TAP;
        rst_state.feed    = WDT_FEED_IDLE;
        rst_state.waitreq = 1'b1;
    endfunction

    function automatic logic [31:0] read_mux(
        input wdt_state_t  s,
        input logic [4:0]  addr
    );
        read_mux = 32'h0000_0000;
        case (addr)
            `WDT_OFF_CTRL:
            begin
                read_mux[`WDT_CTRL_WDE] = s.watchdog_mode_enable;
                read_mux[`WDT_CTRL_RUN] = s.run;
                read_mux[`WDT_CTRL_OSC] = s.osc;
                read_mux[`WDT_CTRL_TAP_HI:`WDT_CTRL_TAP_LO] = s.tap;
            end
            `WDT_OFF_RELOAD:
            begin
                read_mux[7:0] = s.reload;
            end
            `WDT_OFF_FEED:
            begin
                read_mux[0] = (s.feed == WDT_FEED_ARMED);
            end
            `WDT_OFF_COUNT:
            begin
                read_mux[7:0] = s.count;
                read_mux[19:8] = s.presc;
            end
            `WDT_OFF_STATUS:
            begin
                read_mux[2:0] = s.status;
            end
            `WDT_OFF_MASK:
            begin
                read_mux[2:0] = s.mask;
            end
            default:
            begin
                read_mux = 32'h0000_0000;
            end
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic       wr_go;
        logic       wr_lo;
        logic [7:0] wbyte;
        logic       feed_done;
        logic       active;
        logic       pre_en;
        logic       wdog_trig;
        logic       sw_trig;
        logic [2:0] st_set;
        logic [2:0] st_clr;

        next_q = q;
        wr_go = avs_req_i.write && !q.waitreq;
        wr_lo = wr_go && avs_req_i.byteenable[0];
        wbyte = avs_req_i.writedata[7:0];
        feed_done = 1'b0;
        wdog_trig = 1'b0;
        sw_trig = 1'b0;
        st_set = 3'h0;
        st_clr = 3'h0;
        active = 1'b0;
        pre_en = 1'b0;

        // ****************************************************************
        // Bus slave: one wait cycle, then the access completes
        // ****************************************************************
        next_q.waitreq = 1'b1;
        if ((avs_req_i.read || avs_req_i.write) && q.waitreq)
        begin
            next_q.waitreq = 1'b0;
            if (avs_req_i.read)
            begin
                next_q.rdata = read_mux(q, avs_req_i.address);
            end
        end

        // ****************************************************************
        // Two-write feed sequence; a write without byte lane 0 is ignored
        // ****************************************************************
        if (wr_lo && avs_req_i.address == `WDT_OFF_FEED)
        begin
            case (q.feed)
                WDT_FEED_IDLE:
                begin
                    if (wr_lo && wbyte == `WDT_FEED_FIRST)
                    begin
                        next_q.feed = WDT_FEED_ARMED;
                    end
                end
                WDT_FEED_ARMED:
                begin
                    next_q.feed = WDT_FEED_IDLE;
                    if (wr_lo && wbyte == `WDT_FEED_SECOND)
                    begin
                        feed_done = 1'b1;
                    end
                end
                default:
                begin
                    next_q.feed = WDT_FEED_IDLE;
                end
            endcase
        end

        // ****************************************************************
        // Clock select and power-down gating
        // ****************************************************************
        active = (q.watchdog_mode_enable || q.run)
                 && !(pd_i && !q.osc);
        pre_en = active && (q.osc ? osc_tick : 1'b1);

        // ****************************************************************
        // Prescaler and down counter
        // ****************************************************************
        if (feed_done)
        begin
            next_q.count = q.reload;
            next_q.presc = 12'h000;
        end
        else if (pre_en)
        begin
            next_q.presc = q.presc + 12'h001;
            if (tap_hit(q.presc, q.tap))
            begin
                if (q.count == 8'h00)
                begin
                    next_q.count = q.reload;
                    if (q.watchdog_mode_enable)
                    begin
                        wdog_trig = 1'b1;
                        st_set[`WDT_ST_WDOG] = 1'b1;
                    end
                    else
                    begin
                        st_set[`WDT_ST_TIMER] = 1'b1;
                    end
                end
                else
                begin
                    next_q.count = q.count - 8'h01;
                end
            end
        end

        // ****************************************************************
        // Register writes
        // ****************************************************************
        if (wr_lo)
        begin
            case (avs_req_i.address)
                `WDT_OFF_CTRL:
                begin
                    next_q.watchdog_mode_enable = wbyte[`WDT_CTRL_WDE];
                    next_q.run = wbyte[`WDT_CTRL_RUN];
                    next_q.osc = wbyte[`WDT_CTRL_OSC];
                    next_q.tap =
                        wbyte[`WDT_CTRL_TAP_HI:`WDT_CTRL_TAP_LO];
                end
                `WDT_OFF_RELOAD:
                begin
                    next_q.reload = wbyte;
                end
                `WDT_OFF_STATUS:
                begin
                    st_clr = wbyte[2:0];
                end
                `WDT_OFF_MASK:
                begin
                    next_q.mask = wbyte[2:0];
                end
                `WDT_OFF_AUX:
                begin
                    if (wbyte[`WDT_AUX_SWRST])
                    begin
                        sw_trig = 1'b1;
                        st_set[`WDT_ST_SWRST] = 1'b1;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // ****************************************************************
        // Sticky status, a new event beats its own clear
        // ****************************************************************
        next_q.status = (q.status & ~st_clr) | st_set;
        next_q.irq = |(next_q.status & next_q.mask);

        // ****************************************************************
        // System reset pulse; watchdog state is left alone
        // ****************************************************************
        if ((wdog_trig || sw_trig) && q.rst_cnt == 5'h00)
        begin
            next_q.rst_cnt = RST_CNT;
        end
        else if (q.rst_cnt != 5'h00)
        begin
            next_q.rst_cnt = q.rst_cnt - 5'h01;
        end
        next_q.sys_rst = (next_q.rst_cnt != 5'h00);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Only the power-on reset clears the watchdog
    always_ff @(posedge clk_i)
    begin
        if (software_reset_bit_i)
        begin
            q <= rst_state();
        end
        else
        begin
            q <= next_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_rsp_o.readdata    = q.rdata;
    assign avs_rsp_o.waitrequest = q.waitreq;
    assign sys_rst_o             = q.sys_rst;
    assign irq_o                 = q.irq;
endmodule

// File: bench/wdt_top_props.sv
module wdt_top_props
#(
    parameter int RST_LEN = 16
) (
    input wire logic                  clk_i,
    input wire logic                  software_reset_bit_i,
    input wire wdt_pkg::wdt_avs_req_t avs_req_i,
    input wire logic                  pd_i,
    input wire wdt_pkg::wdt_avs_rsp_t avs_rsp_o,
    input wire logic                  sys_rst_o,
    input wire logic                  irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    // ************************************************
    // Reset pulse length counter
    // ************************************************
    logic [7:0] hi_cnt;
    logic       req;
    logic       done;

    assign req  = avs_req_i.read || avs_req_i.write;
    assign done = avs_req_i.write && !avs_rsp_o.waitrequest
                  && avs_req_i.byteenable[0];

    always_ff @(posedge clk_i)
        if (software_reset_bit_i || !sys_rst_o)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= hi_cnt + 8'h01;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (software_reset_bit_i);

    chk_rst_len: assert property (
        $fell(sys_rst_o) && !$past(software_reset_bit_i) |-> hi_cnt == 8'(RST_LEN))
        else $error("reset pulse length wrong");
    chk_rst_cap: assert property (
        sys_rst_o |-> hi_cnt < 8'(RST_LEN))
        else $error("reset pulse too long");
    chk_sw_reset: assert property (
        done && avs_req_i.address == 5'h18 && avs_req_i.writedata[0]
        |-> ##[1:2] sys_rst_o)
        else $error("software reset missing");
    chk_mask_off: assert property (
        done && avs_req_i.address == 5'h14
        && avs_req_i.writedata[2:0] == 3'h0 |-> ##2 !irq_o)
        else $error("masked interrupt raised");
    chk_after_reset: assert property (
        $fell(software_reset_bit_i) |-> avs_rsp_o.waitrequest && !sys_rst_o && !irq_o)
        else $error("outputs wrong after reset");
    chk_wait_one: assert property (
        req && avs_rsp_o.waitrequest |=> !avs_rsp_o.waitrequest)
        else $error("no answer after one wait");
    chk_wait_idle: assert property (!req |=> avs_rsp_o.waitrequest)
        else $error("answer without request");
    chk_rdata_hold: assert property (
        !avs_rsp_o.waitrequest |=> $stable(avs_rsp_o.readdata))
        else $error("read data not held");
    chk_rdata_top: assert property (
        !avs_rsp_o.waitrequest |-> avs_rsp_o.readdata[31:20] == 12'h000)
        else $error("upper read bits set");
endmodule

bind wdt_top wdt_top_props #(.RST_LEN(RST_LEN)) u_props (
    .clk_i     (clk_i),
    .software_reset_bit_i    (software_reset_bit_i),
    .avs_req_i (avs_req_i),
    .pd_i      (pd_i),
    .avs_rsp_o (avs_rsp_o),
    .sys_rst_o (sys_rst_o),
    .irq_o     (irq_o)
);

// File: bench/testbench.sv
`include "wdt_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;

    logic         clk_i = 1'b0;
    logic         software_reset_bit_i = 1'b1;
    logic         pd_i = 1'b0;
    wdt_avs_req_t req = '0;
    wdt_avs_rsp_t rsp;
    logic         sys_rst_o;
    logic         irq_o;
    logic         seen_rst = 1'b0;
    logic [31:0]  rd;
    int           n_mismatch = 0;
    int           n_compared = 0;
    int           rl;
    int           ex;
    int           rv[8] = '{'h70, 'hff, 0, 'hff, 0, 0, 0, 0};
    logic [7:0]   ctl[3] = '{8'h02, 8'h12, 8'h06};

    wdt_top #(.OSC_DIV(4)) dut (
        .clk_i     (clk_i),
        .software_reset_bit_i    (software_reset_bit_i),
        .avs_req_i (req),
        .pd_i      (pd_i),
        .avs_rsp_o (rsp),
        .sys_rst_o (sys_rst_o),
        .irq_o     (irq_o)
    );

    initial
        forever #4 clk_i = ~clk_i;

    always @(posedge clk_i)
        if (sys_rst_o === 1'b1)
            seen_rst <= 1'b1;

    // ************************************************
    // Bus, compare and wait tasks
    // ************************************************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d,
                       logic [3:0] be = 4'hf);
        int n;
        n = 0;
        req <= '{read: !wr, write: wr, address: a, writedata: d,
                 byteenable: be};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (rsp.waitrequest !== 1'b0 && n < 50);
        rd = rsp.readdata;
        req <= '0;
        if (n >= 50)
            chk("waitrequest", 0, 1);
        @(posedge clk_i);
    endtask

    task automatic feed();
        bus(1, `WDT_OFF_FEED, 32'(`WDT_FEED_FIRST));
        bus(1, `WDT_OFF_FEED, 32'(`WDT_FEED_SECOND));
    endtask

    task automatic wait_evt(logic rst, int e, int tol, string nm);
        int n;
        n = 0;
        while ((rst ? sys_rst_o : irq_o) !== 1'b1 && n < e + tol)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(nm, 1, (rst ? sys_rst_o : irq_o) === 1'b1 && n >= e - tol);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        summarize();
    end

    // ************************************************
    // Tests
    // ************************************************
    initial
    begin
        void'($urandom(20657));
        repeat (10) @(posedge clk_i);
        software_reset_bit_i <= 1'b0;
        @(posedge clk_i);
        foreach (rv[i])
        begin
            bus(0, 5'(i * 4), 0);
            chk("reset value", rv[i], rd);
        end
        $display("test reset values done");

        bus(1, `WDT_OFF_RELOAD, 32'h33, 4'he);
        bus(1, `WDT_OFF_RELOAD, 32'h20);
        bus(1, `WDT_OFF_FEED, 32'(`WDT_FEED_FIRST));
        bus(0, `WDT_OFF_FEED, 0);
        chk("feed armed", 1, rd);
        bus(1, `WDT_OFF_FEED, 0);
        bus(1, `WDT_OFF_FEED, 32'(`WDT_FEED_SECOND));
        bus(1, `WDT_OFF_COUNT, 32'h12);
        bus(0, `WDT_OFF_COUNT, 0);
        chk("count unfed", 32'hff, rd);
        feed();
        bus(0, `WDT_OFF_COUNT, 0);
        chk("count fed", 32'h20, rd);
        $display("test feed done");

        for (int k = 0; k < 3; k++)
        begin
            rl = $urandom_range(1, 6);
            ex = (rl + 1) << (ctl[k][6:4] + 5);
            if (ctl[k][2])
                ex = ex * 4;
            pd_i <= (k == 2);
            bus(1, `WDT_OFF_CTRL, 32'(ctl[k]));
            bus(1, `WDT_OFF_STATUS, 32'h7);
            bus(1, `WDT_OFF_MASK, 32'h1);
            bus(1, `WDT_OFF_RELOAD, 32'(rl));
            feed();
            wait_evt(0, ex, 6, "interval expiry");
            bus(1, `WDT_OFF_CTRL, 0);
            bus(0, `WDT_OFF_STATUS, 0);
            chk("interval status", 1, rd);
            bus(1, `WDT_OFF_MASK, 0);
            chk("irq masked", 0, irq_o);
            bus(1, `WDT_OFF_MASK, 32'h1);
            chk("irq unmasked", 1, irq_o);
            bus(1, `WDT_OFF_STATUS, 32'h1);
            @(posedge clk_i);
            chk("irq cleared", 0, irq_o);
            chk("no reset in timer mode", 0, seen_rst);
        end
        $display("test interval timer done");

        pd_i <= 1'b0;
        bus(1, `WDT_OFF_RELOAD, 32'h2);
        bus(1, `WDT_OFF_CTRL, 32'h1);
        repeat (4)
        begin
            feed();
            repeat (40) @(posedge clk_i);
        end
        chk("fed in time", 0, seen_rst);
        feed();
        wait_evt(1, 96, 3, "watchdog expiry");
        bus(0, `WDT_OFF_CTRL, 0);
        chk("mode kept", 1, rd);
        bus(1, `WDT_OFF_CTRL, 0);
        bus(0, `WDT_OFF_STATUS, 0);
        chk("watchdog status", 2, rd);
        repeat (20) @(posedge clk_i);
        $display("test watchdog done");

        seen_rst <= 1'b0;
        bus(1, `WDT_OFF_STATUS, 32'h7);
        bus(1, `WDT_OFF_RELOAD, 0);
        pd_i <= 1'b1;
        bus(1, `WDT_OFF_CTRL, 32'h1);
        feed();
        repeat (200) @(posedge clk_i);
        chk("stopped in power-down", 0, seen_rst);
        bus(1, `WDT_OFF_CTRL, 0);
        pd_i <= 1'b0;
        $display("test power-down done");

        bus(1, `WDT_OFF_AUX, 32'h1);
        wait_evt(1, 1, 1, "software reset");
        bus(0, `WDT_OFF_STATUS, 0);
        chk("software reset status", 4, rd);
        bus(0, `WDT_OFF_AUX, 0);
        chk("aux reads zero", 0, rd);
        $display("test software reset done");
        summarize();
    end
endmodule
